// ==== logic/usdcr_pkg.sv ====
// package of constants for the usb string descriptor configuration registers
// Overview of operation
// - The language high-byte register supplies the upper byte of the language code answered at string index 0.
// - Only one language code is advertised, so index 0 always answers with exactly one code.
// - The language high byte resets to 04h so that the advertised code is 0409h.
// - Language bytes, maker length and product length accept loads only while the string override enable is 1.
// - The serial string length accepts loads only while the serial override enable is 1.
// - Reserved upper bits of the length registers cannot be written and always read as zero.
// - The serial length is a six-bit field at bits 5:0 that resets to 18h.
// - A nonzero serial length makes index 1 answer with a string of that many bytes.
// - The maker length is a seven-bit field at bits 6:0 that resets to zero, and zero means no maker string.
// - A nonzero maker length makes index 3 answer with a string of that many bytes.
// - The language low byte resets to 09h as the lower byte of the single language code.
// - A nonzero product length makes the product index answer with a string of that many bytes.
package usdcr_pkg;

    // ************************************************************
    // bus widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LEN_W = 7;
    localparam int LANG_W = 16;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_LANG_LOW = 8'h20;
    localparam logic [7:0] OFS_LANG_HIGH = 8'h21;
    localparam logic [7:0] OFS_SERIAL_LEN = 8'h22;
    localparam logic [7:0] OFS_MAKER_LEN = 8'h23;
    localparam logic [7:0] OFS_PRODUCT_LEN = 8'h24;

    // ************************************************************
    // field layouts
    // ************************************************************
    localparam int SERIAL_LEN_W = 6;
    localparam int MAKER_LEN_W = 7;
    localparam int PRODUCT_LEN_W = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_LANG_LOW = 8'h09;
    localparam logic [7:0] RST_LANG_HIGH = 8'h04;
    localparam logic [5:0] RST_SERIAL_LEN = 6'h18;
    localparam logic [6:0] RST_MAKER_LEN = 7'h00;
    localparam logic [6:0] RST_PRODUCT_LEN = 7'h00;

    // ************************************************************
    // string indices and descriptor figures
    // ************************************************************
    localparam logic [7:0] IDX_LANG = 8'h00;
    localparam logic [7:0] IDX_SERIAL = 8'h01;
    localparam logic [7:0] IDX_PRODUCT = 8'h02;
    localparam logic [7:0] IDX_MAKER = 8'h03;
    localparam logic [6:0] LANG_TABLE_LEN = 7'h02;  // one code, two bytes

endpackage

// ==== logic/usdcr_regs.sv ====
// string descriptor configuration registers with descriptor lookup
module usdcr_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic string_override_enable,
    input wire logic serial_override_enable,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [usdcr_pkg::ADDR_W-1:0] cfg_addr,
    input wire logic [usdcr_pkg::DATA_W-1:0] cfg_wr_data,
    output logic [usdcr_pkg::DATA_W-1:0] cfg_rd_data,
    output logic cfg_rd_valid,
    input wire logic desc_req,
    input wire logic [usdcr_pkg::ADDR_W-1:0] desc_index,
    output logic desc_valid,
    output logic desc_present,
    output logic [usdcr_pkg::LEN_W-1:0] desc_length,
    output logic [usdcr_pkg::LANG_W-1:0] desc_lang_code
);
    import usdcr_pkg::*;

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic [7:0] lang_low;
        logic [7:0] lang_high;
        logic [SERIAL_LEN_W-1:0] serial_len;
        logic [MAKER_LEN_W-1:0] maker_len;
        logic [PRODUCT_LEN_W-1:0] product_len;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic ans_valid;
        logic ans_present;
        logic [LEN_W-1:0] ans_len;
        logic [LANG_W-1:0] ans_lang;
    } usdcr_state_s;

    usdcr_state_s s;
    usdcr_state_s next_s;

    // ************************************************************
    // write permission and read mux
    // ************************************************************
    logic str_wr_ok;
    logic ser_wr_ok;
    logic [DATA_W-1:0] rd_mux;

    // loads only pass while the matching override enable is set
    assign str_wr_ok = cfg_wr && string_override_enable;
    assign ser_wr_ok = cfg_wr && serial_override_enable;

    // read value of the addressed register, reserved bits forced low
    always_comb begin
        case (cfg_addr)
            OFS_LANG_LOW: rd_mux = s.lang_low;
            OFS_LANG_HIGH: rd_mux = s.lang_high;
            OFS_SERIAL_LEN: rd_mux = {2'h0, s.serial_len};
            OFS_MAKER_LEN: rd_mux = {1'h0, s.maker_len};
            OFS_PRODUCT_LEN: rd_mux = {1'h0, s.product_len};
            default: rd_mux = 8'h00;  // unmapped offsets read zero
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    // register loads, read answer and descriptor lookup
    always_comb begin
        next_s = s;
        next_s.rd_valid = cfg_rd;
        next_s.ans_valid = desc_req;
        if (cfg_rd) begin
            next_s.rd_data = rd_mux;
        end
        // a refused write leaves the register untouched
        if (str_wr_ok && cfg_addr == OFS_LANG_LOW) begin
            next_s.lang_low = cfg_wr_data;
        end
        if (str_wr_ok && cfg_addr == OFS_LANG_HIGH) begin
            next_s.lang_high = cfg_wr_data;
        end
        if (ser_wr_ok && cfg_addr == OFS_SERIAL_LEN) begin
            next_s.serial_len = cfg_wr_data[SERIAL_LEN_W-1:0];
        end
        if (str_wr_ok && cfg_addr == OFS_MAKER_LEN) begin
            next_s.maker_len = cfg_wr_data[MAKER_LEN_W-1:0];
        end
        if (str_wr_ok && cfg_addr == OFS_PRODUCT_LEN) begin
            next_s.product_len = cfg_wr_data[PRODUCT_LEN_W-1:0];
        end
        // descriptor answer, taken from the values held before this edge
        if (desc_req) begin
            next_s.ans_lang = 16'h0000;
            case (desc_index)
                IDX_LANG: begin
                    next_s.ans_present = 1'b1;
                    next_s.ans_len = LANG_TABLE_LEN;
                    next_s.ans_lang = {s.lang_high, s.lang_low};
                end
                IDX_SERIAL: begin
                    next_s.ans_present = (s.serial_len != 6'h00);
                    next_s.ans_len = {1'h0, s.serial_len};
                end
                IDX_PRODUCT: begin
                    next_s.ans_present = (s.product_len != 7'h00);
                    next_s.ans_len = s.product_len;
                end
                IDX_MAKER: begin
                    // loader keeps this at 64 or less, no clamp here
                    next_s.ans_present = (s.maker_len != 7'h00);
                    next_s.ans_len = s.maker_len;
                end
                default: begin
                    next_s.ans_present = 1'b0;
                    next_s.ans_len = 7'h00;
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    // synchronous reset loads the documented defaults
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s.lang_low <= RST_LANG_LOW;
            s.lang_high <= RST_LANG_HIGH;
            s.serial_len <= RST_SERIAL_LEN;
            s.maker_len <= RST_MAKER_LEN;
            s.product_len <= RST_PRODUCT_LEN;
            s.rd_data <= 8'h00;
            s.rd_valid <= 1'b0;
            s.ans_valid <= 1'b0;
            s.ans_present <= 1'b0;
            s.ans_len <= 7'h00;
            s.ans_lang <= 16'h0000;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // all data outputs come from the state register, desc_length forced to zero while ans_present is clear
    assign cfg_rd_data = s.rd_data;
    assign cfg_rd_valid = s.rd_valid;
    assign desc_valid = s.ans_valid;
    assign desc_present = s.ans_present;
    assign desc_length = s.ans_present ? s.ans_len : 7'h00;
    assign desc_lang_code = s.ans_lang;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // index 0 answers with the current language bytes
    a_lang_code_answer: assert property (
        desc_req && desc_index == IDX_LANG
        |=> desc_valid && desc_present
            && desc_lang_code == {$past(s.lang_high), $past(s.lang_low)})
        else $error("language code answer wrong");

    // index 0 holds exactly one two-byte code
    a_single_lang_len: assert property (
        desc_req && desc_index == IDX_LANG |=> desc_length == 7'h02)
        else $error("language table not one code");

    // language defaults after reset release
    a_lang_high_default: assert property (
        $rose(rst_n) |-> s.lang_high == 8'h04)
        else $error("language high byte default wrong");

    a_lang_low_default: assert property (
        $rose(rst_n) |-> s.lang_low == 8'h09)
        else $error("language low byte default wrong");

    // string group frozen while its override is clear
    a_string_locked: assert property (
        !string_override_enable
        |=> $stable(s.lang_high) && $stable(s.lang_low)
            && $stable(s.maker_len) && $stable(s.product_len))
        else $error("string register changed without override");

    // maker length takes a write while the string override is set
    a_string_loads: assert property (
        cfg_wr && string_override_enable && cfg_addr == OFS_MAKER_LEN
        |=> s.maker_len == $past(cfg_wr_data[6:0]))
        else $error("maker length write lost");

    // serial length frozen unless its override is set
    a_serial_locked: assert property (
        !(serial_override_enable && cfg_wr && cfg_addr == OFS_SERIAL_LEN)
        |=> $stable(s.serial_len))
        else $error("serial length changed without override");

    // reserved bits of the serial and maker lengths read as zero one cycle after the request
    a_rsvd_read_zero: assert property (
        cfg_rd && (cfg_addr == OFS_SERIAL_LEN || cfg_addr == OFS_MAKER_LEN)
        |=> cfg_rd_valid && cfg_rd_data[7] == 1'b0
            && ($past(cfg_addr) != OFS_SERIAL_LEN || cfg_rd_data[6] == 1'b0))
        else $error("reserved length bits read nonzero");

    // serial default present after reset
    a_serial_default: assert property (
        $rose(rst_n) |-> s.serial_len == 6'h18)
        else $error("serial length default wrong");

    // serial index answers with the serial length
    a_serial_answer: assert property (
        desc_req && desc_index == IDX_SERIAL
        |=> desc_present == ($past(s.serial_len) != 6'h00)
            && desc_length == {1'b0, $past(s.serial_len)})
        else $error("serial answer wrong");

    // maker string absent by default: length zero at reset release
    a_maker_default: assert property (
        $rose(rst_n) |-> s.maker_len == 7'h00)
        else $error("maker string offered after reset");

    // maker index answers with the maker length
    a_maker_answer: assert property (
        desc_req && desc_index == IDX_MAKER
        |=> desc_present == ($past(s.maker_len) != 7'h00)
            && desc_length == $past(s.maker_len))
        else $error("maker answer wrong");

    // product index answers with the product length
    a_product_answer: assert property (
        desc_req && desc_index == IDX_PRODUCT
        |=> desc_present == ($past(s.product_len) != 7'h00)
            && desc_length == $past(s.product_len))
        else $error("product answer wrong");

    // an absent index never reports bytes
    a_absent_no_bytes: assert property (
        desc_valid && !desc_present |-> desc_length == 7'h00)
        else $error("absent index reports bytes");

    // answers arrive exactly one cycle after the request
    a_answer_timing: assert property (
        desc_valid == $past(desc_req) && cfg_rd_valid == $past(cfg_rd))
        else $error("answer timing wrong");

    // ************************************************************
    // covers
    // ************************************************************
    c_string_write: cover property (
        cfg_wr && string_override_enable && cfg_addr == OFS_LANG_HIGH);
    c_serial_write: cover property (
        cfg_wr && serial_override_enable && cfg_addr == OFS_SERIAL_LEN);
    c_serial_absent: cover property (
        desc_req && desc_index == IDX_SERIAL && s.serial_len == 6'h00);
    c_maker_present: cover property (
        desc_req && desc_index == IDX_MAKER && s.maker_len != 7'h00);

endmodule // usdcr_regs

// ==== test/test_usdcr_regs.sv ====
// self-checking bench for the string descriptor configuration registers
module test_usdcr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic str_en = 1'b0;
    logic ser_en = 1'b0;
    logic cfg_wr, cfg_rd, desc_req, cfg_rd_valid, desc_valid, desc_present;
    logic [7:0] cfg_addr, cfg_wr_data, cfg_rd_data, desc_index;
    logic [6:0] desc_length;
    logic [15:0] desc_lang_code;
    logic [7:0] rd_q[$];
    logic [23:0] desc_q[$];
    logic [7:0] lh, ll, sl, ml, pl;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #2 core_clk = ~core_clk;

    usdcr_regs i_usdcr_regs (.core_clk(core_clk), .rst_n(rst_n),
        .string_override_enable(str_en), .serial_override_enable(ser_en),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
        .cfg_rd_valid(cfg_rd_valid), .desc_req(desc_req),
        .desc_index(desc_index), .desc_valid(desc_valid),
        .desc_present(desc_present), .desc_length(desc_length),
        .desc_lang_code(desc_lang_code));

    usdcr_loader i_usdcr_loader (.core_clk(core_clk), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
        .desc_req(desc_req), .desc_index(desc_index));

    // ************************************************************
    // comparison, notes and verdict
    // ************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        i_usdcr_loader.rd(a);
    endtask

    task automatic dq(input logic [7:0] idx, input logic [23:0] e);
        desc_q.push_back(e);
        i_usdcr_loader.desc(idx);
    endtask

    task automatic done(input string name);
        repeat (4) @(posedge core_clk);
        check(24'(rd_q.size() + desc_q.size()), 24'h0);
        $display("test %s finished", name);
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watcher: each answer takes the oldest note off its queue
    always @(negedge core_clk) begin
        if (cfg_rd_valid === 1'b1) begin
            if (rd_q.size() == 0) check(24'h1, 24'h0);
            else check({16'h0, cfg_rd_data}, {16'h0, rd_q.pop_front()});
        end
        if (desc_valid === 1'b1) begin
            if (desc_q.size() == 0) check(24'h1, 24'h0);
            else check({desc_present, desc_length, desc_lang_code},
                desc_q.pop_front());
        end
    end

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        void'($urandom(7979));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h20, 8'h09);
        rd(8'h21, 8'h04);
        rd(8'h22, 8'h18);
        rd(8'h23, 8'h00);
        rd(8'h24, 8'h00);
        rd(8'h30, 8'h00);
        dq(8'h00, 24'h820409);
        dq(8'h01, 24'h980000);
        dq(8'h02, 24'h000000);
        dq(8'h03, 24'h000000);
        dq(8'h05, 24'h000000);
        done("reset values");
        i_usdcr_loader.wr(8'h20, 8'hff);
        i_usdcr_loader.wr(8'h21, 8'hff);
        i_usdcr_loader.wr(8'h22, 8'h3f);
        i_usdcr_loader.wr(8'h23, 8'h10);
        i_usdcr_loader.wr(8'h24, 8'h11);
        rd(8'h20, 8'h09);
        rd(8'h21, 8'h04);
        rd(8'h22, 8'h18);
        rd(8'h23, 8'h00);
        rd(8'h24, 8'h00);
        done("locked writes");
        str_en <= 1'b1;
        ser_en <= 1'b1;
        lh = 8'($urandom);
        ll = 8'($urandom);
        sl = 8'($urandom) | 8'hc0;
        ml = 8'($urandom % 64 + 1) | 8'h80;
        pl = 8'($urandom % 64 + 1) | 8'h80;
        i_usdcr_loader.wr(8'h20, ll);
        i_usdcr_loader.wr(8'h21, lh);
        i_usdcr_loader.wr(8'h22, sl);
        i_usdcr_loader.wr(8'h23, ml);
        i_usdcr_loader.wr(8'h24, pl);
        rd(8'h20, ll);
        rd(8'h21, lh);
        rd(8'h22, {2'b00, sl[5:0]});
        rd(8'h23, {1'b0, ml[6:0]});
        rd(8'h24, {1'b0, pl[6:0]});
        dq(8'h00, {8'h82, lh, ll});
        dq(8'h01, {|sl[5:0], 1'b0, sl[5:0], 16'h0});
        dq(8'h02, {1'b1, pl[6:0], 16'h0});
        dq(8'h03, {1'b1, ml[6:0], 16'h0});
        done("unlocked writes");
        i_usdcr_loader.wr(8'h22, 8'h00);
        dq(8'h01, 24'h000000);
        ser_en <= 1'b0;
        i_usdcr_loader.wr(8'h22, 8'h05);
        rd(8'h22, 8'h00);
        dq(8'h01, 24'h000000);
        done("serial absent");
        // reset in mid-run brings back the language, serial length and maker length defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h20, 8'h09);
        rd(8'h21, 8'h04);
        rd(8'h22, 8'h18);
        rd(8'h23, 8'h00);
        dq(8'h00, 24'h820409);
        dq(8'h01, 24'h980000);
        done("second reset");
        print_verdict();
    end
endmodule // test_usdcr_regs

// ==== test/usdcr_loader.sv ====
// partner model: loader host on the register port, usb host asking for strings
module usdcr_loader
    import usdcr_pkg::*;
(
    input wire logic core_clk,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [usdcr_pkg::ADDR_W-1:0] cfg_addr,
    output logic [usdcr_pkg::DATA_W-1:0] cfg_wr_data,
    output logic desc_req,
    output logic [usdcr_pkg::ADDR_W-1:0] desc_index
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels at time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        desc_req = 1'b0;
        cfg_addr = 8'h5a;
        cfg_wr_data = 8'ha5;
        desc_index = 8'h3c;
    end

    // one write strobe; the loader never offers a maker length above 64
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == OFS_MAKER_LEN && v[6:0] > 7'h40) begin
            v[6:0] = 7'h40;
        end
        @(posedge core_clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wr_data <= v;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;  // released lines show the inverse
        cfg_wr_data <= ~v;
    endtask

    // one read strobe
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge core_clk);
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
    endtask

    // one descriptor lookup
    task automatic desc(input logic [7:0] idx);
        @(posedge core_clk);
        desc_req <= 1'b1;
        desc_index <= idx;
        @(posedge core_clk);
        desc_req <= 1'b0;
        desc_index <= ~idx;
    endtask
endmodule // usdcr_loader
